// >>> rtl/hrap_params.svh
// Contract
// - Both straps high parallel; host strap only serial
// - Serial port runs up to 4 Mbps
// - Full duplex, shifts only while select active
// - Six nibbles, 12-bit eoc, byte registers
// - Eight-bit op: flag then 3-bit address
// - Addresses 0-5 nibbles; 6 eoc; 7 byte
// - Four data bits follow address, both directions
// - Eoc via address 6, two 8-bit ops
// - Second eoc op carries low eight bits
// - Eoc also as one 16-bit transfer
// - Byte access: address 7 plus 4-bit index
// - Second op carries byte data either way
// - Byte access also as one 16-bit transfer
// - Interrupt request output for host service
// - Parallel: byte port, select and direction
// - Pointer holds address, nibble write data
// - Then two reads or one write
// - Parallel interrupt open drain on status change
// - Overlay config bit 3 selects line-card timing
// - Nibble read returns value on bits 3:0
// - Eoc read: high nibble first, low byte next
`ifndef HRAP_PARAMS_SVH
`define HRAP_PARAMS_SVH

// ==========================================
// Addresses and fields
`define HRAP_NIB_COUNT     6
`define HRAP_NIB_EOC       3'h6
`define HRAP_NIB_BYTE      3'h7
`define HRAP_RW_READ       1'b1
`define HRAP_RW_BIT        7
`define HRAP_ACK_NIB       4'h0
`define HRAP_OFC_IDX       4'h6
`define HRAP_OFC_GCI_BIT   3
`define HRAP_BYTE_LAST     3'h7
`define HRAP_HDR_LAST      3'h3
`define HRAP_DATA_FIRST    3'h4

// ==========================================
// Reset values
`define HRAP_NIB_RST       4'h0
`define HRAP_EOC_RST       12'h000
`define HRAP_BYTE_RST      8'h00

// ==========================================
// Timing
`define HRAP_SER_MAX_KBPS  4000

`endif

// >>> rtl/hrap_pkg.sv
package hrap_pkg;

  // ==========================================
  // Access kinds and write carrier
  typedef enum logic [1:0] {
    HRAP_K_NIB  = 2'h0,
    HRAP_K_EOC  = 2'h1,
    HRAP_K_BYTE = 2'h2
  } hrap_kind_t;

  typedef struct packed {
    hrap_kind_t  kind;
    logic [3:0]  addr;
    logic [11:0] data;
  } hrap_wr_t;

  // ==========================================
  // Parallel pointer sequencer
  typedef enum logic [3:0] {
    HRAP_P_IDLE  = 4'b0001,
    HRAP_P_WDATA = 4'b0010,
    HRAP_P_READ1 = 4'b0100,
    HRAP_P_READ2 = 4'b1000
  } hrap_pstate_t;

endpackage : hrap_pkg

// >>> rtl/hrap_top.sv
`timescale 1ns/1ps
`include "hrap_params.svh"

module hrap_top #(
  parameter int BYTE_REGS = 16
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        host_vs_linecard_select,
  input  wire logic        parallel_serial_select,
  input  wire logic        serial_port_clock,
  input  wire logic        serial_port_select_n,
  input  wire logic        serial_port_in,
  output logic             serial_port_out,
  output logic             serial_port_out_oe,
  input  wire logic        par_cs_n,
  input  wire logic        par_rw,
  input  wire logic [7:0]  par_data_in,
  output logic      [7:0]  par_data_out,
  output logic             par_data_oe,
  input  wire logic        status_change,
  output logic             irq_n_out,
  output logic             irq_n_oe,
  output logic             tdm_gci_mode,
  output logic      [11:0] eoc_message
);

  // ==========================================
  // Register image
  logic [3:0]  nib_reg  [`HRAP_NIB_COUNT];
  logic [3:0]  nib_next [`HRAP_NIB_COUNT];
  logic [7:0]  byte_reg [BYTE_REGS];
  logic [7:0]  byte_next[BYTE_REGS];
  logic [11:0] eoc_reg;
  logic [11:0] eoc_next;
  logic        irq_reg;
  logic        irq_next;

  // ==========================================
  // Pin synchronisers, system side
  logic [12:0] meta_reg;
  logic [12:0] sync_reg;
  logic        ser_tgl;
  logic        mode_host_reg;
  logic        mode_par_reg;
  logic        cs_prev_reg;
  logic        tgl_prev_reg;
  logic        par_mode;
  logic        ser_mode;
  logic        cs_s;
  logic        rw_s;
  logic [7:0]  d_s;
  logic        cs_fall;
  logic        cs_rise;

  assign cs_s     = sync_reg[10];
  assign rw_s     = sync_reg[8];
  assign d_s      = sync_reg[7:0];
  assign par_mode = mode_host_reg & mode_par_reg;
  assign ser_mode = mode_host_reg & ~mode_par_reg;
  assign cs_fall  = cs_prev_reg & ~cs_s;
  assign cs_rise  = ~cs_prev_reg & cs_s;

  always_ff @(posedge clock) begin
    meta_reg     <= {ser_tgl, host_vs_linecard_select, par_cs_n,
                     parallel_serial_select, par_rw, par_data_in};
    sync_reg     <= meta_reg;
    cs_prev_reg  <= sys_rst ? 1'b1 : cs_s;
    tgl_prev_reg <= sys_rst ? 1'b0 : sync_reg[12];
    // Straps caught while reset is held, frozen afterwards
    if (sys_rst) begin
      mode_host_reg <= sync_reg[11];
      mode_par_reg  <= sync_reg[9];
    end
  end

  // ==========================================
  // Parallel pointer sequencer
  hrap_pkg::hrap_pstate_t pst_reg;
  hrap_pkg::hrap_pstate_t pst_next;
  hrap_pkg::hrap_kind_t   pkind_reg;
  hrap_pkg::hrap_kind_t   pkind_next;
  logic [3:0]             paddr_reg;
  logic [3:0]             paddr_next;
  logic [7:0]             dout_reg;
  logic [7:0]             dout_next;
  logic                   par_wr;
  hrap_pkg::hrap_wr_t     par_word;

  always_comb begin
    pst_next   = pst_reg;
    pkind_next = pkind_reg;
    paddr_next = paddr_reg;
    dout_next  = dout_reg;
    par_wr     = 1'b0;
    par_word   = '{kind: hrap_pkg::HRAP_K_NIB, addr: 4'h0, data: 12'h000};
    if (par_mode && cs_rise && !rw_s) begin
      case (pst_reg)
        hrap_pkg::HRAP_P_WDATA: begin
          // Second byte completes eoc or byte write
          par_wr        = 1'b1;
          par_word.kind = pkind_reg;
          par_word.addr = paddr_reg;
          par_word.data = (pkind_reg == hrap_pkg::HRAP_K_EOC) ?
                          {paddr_reg, d_s} : {4'h0, d_s};
          pst_next      = hrap_pkg::HRAP_P_IDLE;
        end
        hrap_pkg::HRAP_P_IDLE,
        hrap_pkg::HRAP_P_READ1,
        hrap_pkg::HRAP_P_READ2: begin
          // Any write outside the data phase is a fresh pointer
          paddr_next = d_s[3:0];
          if (d_s[6:4] == `HRAP_NIB_EOC) begin
            pkind_next = hrap_pkg::HRAP_K_EOC;
          end else if (d_s[6:4] == `HRAP_NIB_BYTE) begin
            pkind_next = hrap_pkg::HRAP_K_BYTE;
          end else begin
            pkind_next = hrap_pkg::HRAP_K_NIB;
            paddr_next = {1'b0, d_s[6:4]};
          end
          if (d_s[`HRAP_RW_BIT] == `HRAP_RW_READ) begin
            pst_next = hrap_pkg::HRAP_P_READ1;
          end else if (d_s[6:4] < `HRAP_NIB_EOC) begin
            par_wr        = 1'b1;
            par_word.addr = {1'b0, d_s[6:4]};
            par_word.data = {8'h00, d_s[3:0]};
            pst_next      = hrap_pkg::HRAP_P_IDLE;
          end else begin
            pst_next = hrap_pkg::HRAP_P_WDATA;
          end
        end
        default: pst_next = hrap_pkg::HRAP_P_IDLE;
      endcase
    end
    if (par_mode && cs_fall && rw_s) begin
      case (pst_reg)
        hrap_pkg::HRAP_P_READ1: begin
          case (pkind_reg)
            hrap_pkg::HRAP_K_EOC:  dout_next = {4'h0, eoc_reg[11:8]};
            hrap_pkg::HRAP_K_BYTE: dout_next = byte_reg[paddr_reg];
            default:               dout_next = {4'h0, nib_reg[paddr_reg[2:0]]};
          endcase
        end
        hrap_pkg::HRAP_P_READ2: begin
          case (pkind_reg)
            hrap_pkg::HRAP_K_EOC:  dout_next = eoc_reg[7:0];
            hrap_pkg::HRAP_K_BYTE: dout_next = byte_reg[paddr_reg];
            default:               dout_next = {4'h0, nib_reg[paddr_reg[2:0]]};
          endcase
        end
        default: dout_next = 8'h00;
      endcase
    end
    if (par_mode && cs_rise && rw_s) begin
      // At most two reads per pointer
      case (pst_reg)
        hrap_pkg::HRAP_P_READ1: pst_next = hrap_pkg::HRAP_P_READ2;
        hrap_pkg::HRAP_P_READ2: pst_next = hrap_pkg::HRAP_P_IDLE;
        default:                pst_next = pst_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pst_reg   <= hrap_pkg::HRAP_P_IDLE;
      pkind_reg <= hrap_pkg::HRAP_K_NIB;
      paddr_reg <= 4'h0;
      dout_reg  <= 8'h00;
    end else begin
      pst_reg   <= pst_next;
      pkind_reg <= pkind_next;
      paddr_reg <= paddr_next;
      dout_reg  <= dout_next;
    end
  end

  // Byte-wide port driven only while selected for read
  assign par_data_out = dout_reg;
  assign par_data_oe  = par_mode & ~cs_s & rw_s;

  // ==========================================
  // Register file update
  hrap_pkg::hrap_wr_t ser_word;
  logic               ser_wr;
  logic               wr_en;
  hrap_pkg::hrap_wr_t wr_word;

  // Serial word is held stable by its toggle handshake
  assign ser_wr  = ser_mode & (sync_reg[12] != tgl_prev_reg);
  assign wr_en   = ser_wr | par_wr;
  assign wr_word = ser_wr ? ser_word : par_word;

  always_comb begin
    nib_next = nib_reg;
    byte_next = byte_reg;
    eoc_next = eoc_reg;
    irq_next = irq_reg;
    if (wr_en) begin
      case (wr_word.kind)
        hrap_pkg::HRAP_K_EOC:  eoc_next = wr_word.data;
        hrap_pkg::HRAP_K_BYTE: byte_next[wr_word.addr] = wr_word.data[7:0];
        default:               nib_next[wr_word.addr[2:0]] = wr_word.data[3:0];
      endcase
      if (wr_word.kind == hrap_pkg::HRAP_K_NIB && wr_word.addr == `HRAP_ACK_NIB) begin
        irq_next = 1'b0;
      end
    end
    // Set beats acknowledge in the same cycle
    if (status_change) begin
      irq_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < `HRAP_NIB_COUNT; i++) begin
        nib_reg[i] <= `HRAP_NIB_RST;
      end
      for (int j = 0; j < BYTE_REGS; j++) begin
        byte_reg[j] <= `HRAP_BYTE_RST;
      end
      eoc_reg <= `HRAP_EOC_RST;
      irq_reg <= 1'b0;
    end else begin
      nib_reg  <= nib_next;
      byte_reg <= byte_next;
      eoc_reg  <= eoc_next;
      irq_reg  <= irq_next;
    end
  end

  // Open drain in parallel mode, push-pull on serial
  assign irq_n_out    = par_mode ? 1'b0 : ~irq_reg;
  assign irq_n_oe     = par_mode ? irq_reg : ser_mode;
  assign tdm_gci_mode = mode_host_reg & byte_reg[`HRAP_OFC_IDX][`HRAP_OFC_GCI_BIT];
  assign eoc_message  = eoc_reg;

  // ==========================================
  // Serial link, on the host's clock
  logic [4:0]             cnt_reg;
  logic [7:0]             sh_reg;
  logic [3:0]             hdr_reg;
  logic [1:0]             smeta_reg;
  logic [1:0]             ssync_reg;
  logic                   srst;
  logic                   s_ser;
  logic                   ptr_valid_reg;
  logic                   ptr_valid_next;
  logic                   ptr_rw_reg;
  logic                   ptr_rw_next;
  hrap_pkg::hrap_kind_t   ptr_kind_reg;
  hrap_pkg::hrap_kind_t   ptr_kind_next;
  logic [3:0]             ptr_addr_reg;
  logic [3:0]             ptr_addr_next;
  logic                   tgl_reg;
  logic                   tgl_next;
  hrap_pkg::hrap_wr_t     word_reg;
  hrap_pkg::hrap_wr_t     word_next;
  logic [7:0]             full;
  logic                   done;

  assign ser_tgl  = tgl_reg;
  assign ser_word = word_reg;
  assign srst     = ssync_reg[1];
  assign s_ser    = ssync_reg[0];
  assign full     = {sh_reg[6:0], serial_port_in};
  assign done     = cnt_reg[2:0] == `HRAP_BYTE_LAST;

  always_ff @(posedge serial_port_clock) begin
    smeta_reg <= {sys_rst, host_vs_linecard_select & ~parallel_serial_select};
    ssync_reg <= smeta_reg;
  end

  // Frame state ends with the select itself; the link clock may stop
  always_ff @(posedge serial_port_clock or posedge serial_port_select_n) begin
    if (serial_port_select_n) begin
      cnt_reg <= 5'h00;
      sh_reg  <= 8'h00;
      hdr_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
      sh_reg  <= full;
      if (cnt_reg[2:0] == `HRAP_HDR_LAST) begin
        hdr_reg <= full[3:0];
      end
    end
  end

  always_comb begin
    ptr_valid_next = ptr_valid_reg;
    ptr_rw_next    = ptr_rw_reg;
    ptr_kind_next  = ptr_kind_reg;
    ptr_addr_next  = ptr_addr_reg;
    tgl_next       = tgl_reg;
    word_next      = word_reg;
    if (done) begin
      if (ptr_valid_reg) begin
        // Second byte, split or within one 16-bit frame
        ptr_valid_next = 1'b0;
        if (ptr_rw_reg != `HRAP_RW_READ) begin
          word_next.kind = ptr_kind_reg;
          word_next.addr = ptr_addr_reg;
          word_next.data = (ptr_kind_reg == hrap_pkg::HRAP_K_EOC) ?
                           {ptr_addr_reg, full} : {4'h0, full};
          tgl_next = ~tgl_reg;
        end
      end else if (full[6:4] < `HRAP_NIB_EOC) begin
        if (full[`HRAP_RW_BIT] != `HRAP_RW_READ) begin
          word_next.kind = hrap_pkg::HRAP_K_NIB;
          word_next.addr = {1'b0, full[6:4]};
          word_next.data = {8'h00, full[3:0]};
          tgl_next = ~tgl_reg;
        end
      end else begin
        ptr_valid_next = 1'b1;
        ptr_rw_next    = full[`HRAP_RW_BIT];
        ptr_addr_next  = full[3:0];
        ptr_kind_next  = (full[6:4] == `HRAP_NIB_EOC) ?
                         hrap_pkg::HRAP_K_EOC : hrap_pkg::HRAP_K_BYTE;
      end
    end
  end

  always_ff @(posedge serial_port_clock) begin
    if (srst) begin
      ptr_valid_reg <= 1'b0;
      ptr_rw_reg    <= 1'b0;
      ptr_kind_reg  <= hrap_pkg::HRAP_K_NIB;
      ptr_addr_reg  <= 4'h0;
      tgl_reg       <= 1'b0;
      word_reg      <= '{kind: hrap_pkg::HRAP_K_NIB, addr: 4'h0, data: 12'h000};
    end else if (!serial_port_select_n && s_ser) begin
      ptr_valid_reg <= ptr_valid_next;
      ptr_rw_reg    <= ptr_rw_next;
      ptr_kind_reg  <= ptr_kind_next;
      ptr_addr_reg  <= ptr_addr_next;
      tgl_reg       <= tgl_next;
      word_reg      <= word_next;
    end
  end

  // ==========================================
  // Serial read data, launched on the falling edge
  logic [7:0] rd_val;
  logic       rd_en;
  logic [2:0] pos;
  logic       tx_reg;
  logic       tx_oe_reg;

  assign pos = cnt_reg[2:0];

  // Register image is read across domains; host must not race its own writes
  always_comb begin
    rd_val = 8'h00;
    rd_en  = 1'b0;
    if (ptr_valid_reg) begin
      rd_en  = ptr_rw_reg == `HRAP_RW_READ;
      rd_val = (ptr_kind_reg == hrap_pkg::HRAP_K_EOC) ?
               eoc_reg[7:0] : byte_reg[ptr_addr_reg];
    end else if (pos >= `HRAP_DATA_FIRST && hdr_reg[3] == `HRAP_RW_READ) begin
      if (hdr_reg[2:0] < `HRAP_NIB_EOC) begin
        rd_en  = 1'b1;
        rd_val = {4'h0, nib_reg[hdr_reg[2:0]]};
      end else if (hdr_reg[2:0] == `HRAP_NIB_EOC) begin
        rd_en  = 1'b1;
        rd_val = {4'h0, eoc_reg[11:8]};
      end
    end
  end

  always_ff @(negedge serial_port_clock) begin
    if (srst) begin
      tx_reg    <= 1'b0;
      tx_oe_reg <= 1'b0;
    end else if (!serial_port_select_n) begin
      // Last launch kept over the gap, so a split second byte starts ready
      tx_reg    <= rd_val[3'h7 - pos];
      tx_oe_reg <= rd_en & s_ser;
    end
  end

  assign serial_port_out    = tx_reg;
  assign serial_port_out_oe = tx_oe_reg & ~serial_port_select_n;

endmodule : hrap_top

// >>> tb/hrap_host_model.sv
`timescale 1ns/1ps
module hrap_host_model (
  output logic      sck,
  output logic      sel_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic last;
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
    last = 1'b0;
  end
  // ==========
  // Idle clocks, select high
  task automatic idle(input int n);
    repeat (2 * n) #6 sck = ~sck;
  endtask : idle
  // ==========
  // One frame; clock stands still outside it
  task automatic frame(input logic [15:0] tx, input int len, output logic [15:0] rx);
    rx = 16'h0000;
    sel_n = 1'b0;
    for (int i = len - 1; i >= 0; i--) begin
      sdi = tx[i];
      #6 sck = 1'b1;
      last = sdo_oe ? sdo : ~last; // Released line shows no stale value
      rx = {rx[14:0], last};
      #6 sck = 1'b0;
    end
    #6 sel_n = 1'b1;
    sdi = ~sdi;
  endtask : frame
endmodule : hrap_host_model

// >>> tb/hrap_top_props.sv
`timescale 1ns/1ps
module hrap_top_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic host_vs_linecard_select,
  input wire logic parallel_serial_select,
  input wire logic serial_port_select_n,
  input wire logic serial_port_out_oe,
  input wire logic par_cs_n,
  input wire logic par_rw,
  input wire logic par_data_oe,
  input wire logic status_change,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic tdm_gci_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========
  // Mode
  logic par_mode;
  assign par_mode = host_vs_linecard_select && parallel_serial_select;
  // ==========
  // Checks
  chk_ser_oe_idle: assert property (serial_port_select_n |-> !serial_port_out_oe)
    else $error("serial out driven outside a frame");
  chk_par_no_ser: assert property (par_mode |-> !serial_port_out_oe)
    else $error("serial out driven in parallel mode");
  chk_par_oe_mode: assert property (par_data_oe |-> par_mode)
    else $error("parallel data driven in serial mode");
  // Margin covers the two-stage select sync
  chk_par_oe_off: assert property (par_cs_n [*5] |-> !par_data_oe)
    else $error("parallel data driven while deselected");
  chk_par_oe_on: assert property ((par_mode && !par_cs_n && par_rw) [*5] |-> par_data_oe)
    else $error("parallel read not driven");
  chk_irq_push: assert property ((host_vs_linecard_select && !parallel_serial_select)
    |-> irq_n_oe)
    else $error("serial mode interrupt not driven");
  chk_irq_open_drain: assert property (par_mode |-> !irq_n_out)
    else $error("parallel interrupt drives high");
  chk_irq_set_ser: assert property ((status_change && !parallel_serial_select)
    |=> !irq_n_out)
    else $error("serial interrupt not raised");
  chk_irq_set_par: assert property ((status_change && par_mode) |=> irq_n_oe)
    else $error("parallel interrupt not raised");
  chk_gci_host: assert property (tdm_gci_mode |-> host_vs_linecard_select)
    else $error("line-card timing outside host mode");
endmodule : hrap_top_props

bind hrap_top hrap_top_props hrap_top_props_i (
  .clock(clock), .sys_rst(sys_rst),
  .host_vs_linecard_select(host_vs_linecard_select),
  .parallel_serial_select(parallel_serial_select),
  .serial_port_select_n(serial_port_select_n), .serial_port_out_oe(serial_port_out_oe),
  .par_cs_n(par_cs_n), .par_rw(par_rw), .par_data_oe(par_data_oe),
  .status_change(status_change), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
  .tdm_gci_mode(tdm_gci_mode)
);

// >>> tb/tb_host_register_access_port.sv
`timescale 1ns/1ps
module tb_host_register_access_port;
  // ==========
  // Signals
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        host_vs_linecard_select = 1'b1;
  logic        parallel_serial_select = 1'b0;
  logic        sck;
  logic        sel_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        par_cs_n = 1'b1;
  logic        par_rw = 1'b1;
  logic [7:0]  par_data_in = 8'hFF;
  logic [7:0]  par_data_out;
  logic        par_data_oe;
  logic        status_change = 1'b0;
  logic        irq_n_out;
  logic        irq_n_oe;
  logic        tdm_gci_mode;
  logic [11:0] eoc_message;
  logic [15:0] rx;
  logic [7:0]  pd;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #12.5 clock = ~clock;

  hrap_top hrap_top_i (
    .clock(clock), .sys_rst(sys_rst),
    .host_vs_linecard_select(host_vs_linecard_select),
    .parallel_serial_select(parallel_serial_select),
    .serial_port_clock(sck), .serial_port_select_n(sel_n), .serial_port_in(sdi),
    .serial_port_out(sdo), .serial_port_out_oe(sdo_oe),
    .par_cs_n(par_cs_n), .par_rw(par_rw), .par_data_in(par_data_in),
    .par_data_out(par_data_out), .par_data_oe(par_data_oe),
    .status_change(status_change), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .tdm_gci_mode(tdm_gci_mode), .eoc_message(eoc_message)
  );
  hrap_host_model host_i (.sck(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  // ==========
  // Helpers
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic do_reset(input logic par_mode);
    @(posedge clock);
    sys_rst <= 1'b1;
    parallel_serial_select <= par_mode;
    host_i.idle(4); // Link state clears only on serial edges
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : do_reset

  task automatic ser(input logic [15:0] tx, input int len);
    host_i.frame(tx, len, rx);
    repeat (8) @(posedge clock);
  endtask : ser

  task automatic par(input logic rw, input logic [7:0] din);
    @(posedge clock);
    par_cs_n    <= 1'b0;
    par_rw      <= rw;
    par_data_in <= din;
    repeat (6) @(posedge clock);
    pd = par_data_out;
    par_cs_n    <= 1'b1;
    // Data held until the synced select edge has taken it
    repeat (4) @(posedge clock);
    par_data_in <= ~din;
    repeat (2) @(posedge clock);
  endtask : par

  task automatic pulse();
    @(posedge clock);
    status_change <= 1'b1;
    @(posedge clock);
    status_change <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : pulse

  // ==========
  // Scenarios
  task automatic test_ser_nibble();
    for (int a = 0; a < 6; a++) begin
      ser({8'h00, 1'b0, 3'(a), 4'(a + 9)}, 8);
    end
    for (int a = 0; a < 6; a++) begin
      ser({8'h00, 1'b1, 3'(a), 4'h0}, 8);
      cmp("nibble", 16'(a + 9), rx & 16'h000F);
    end
    cmp("serial oe", 16'h0000, {15'h0000, sdo_oe});
    $display("test serial nibble done");
  endtask : test_ser_nibble

  task automatic test_ser_eoc();
    ser({1'b0, 3'h6, 12'h93C}, 16);
    cmp("eoc", 16'h093C, {4'h0, eoc_message});
    ser({8'h00, 1'b1, 3'h6, 4'h0}, 8);
    cmp("eoc high", 16'h0009, rx & 16'h000F);
    ser(16'h0000, 8);
    cmp("eoc low", 16'h003C, rx & 16'h00FF);
    ser({8'h00, 1'b0, 3'h6, 4'h5}, 8);
    ser(16'h00A7, 8);
    ser({1'b1, 3'h6, 12'h000}, 16);
    cmp("eoc 16", 16'h05A7, rx & 16'h0FFF);
    $display("test serial eoc done");
  endtask : test_ser_eoc

  task automatic test_ser_byte();
    ser({1'b0, 3'h7, 4'h6, 8'h08}, 16);
    cmp("gci", 16'h0001, {15'h0000, tdm_gci_mode});
    ser({8'h00, 1'b0, 3'h7, 4'h3}, 8);
    ser(16'h00C5, 8);
    ser({1'b1, 3'h7, 4'h3, 8'h00}, 16);
    cmp("byte 16", 16'h00C5, rx & 16'h00FF);
    ser({8'h00, 1'b1, 3'h7, 4'h6}, 8);
    ser(16'h0000, 8);
    cmp("byte", 16'h0008, rx & 16'h00FF);
    $display("test serial byte done");
  endtask : test_ser_byte

  task automatic test_ser_irq();
    pulse();
    cmp("irq set", 16'h0000, {15'h0000, irq_n_out});
    ser(16'h0000, 8);
    cmp("irq clear", 16'h0001, {15'h0000, irq_n_out});
    $display("test serial irq done");
  endtask : test_ser_irq

  task automatic test_par();
    do_reset(1'b1);
    ser(16'h001F, 8);
    par(1'b0, 8'h35);
    par(1'b0, 8'h90);
    par(1'b1, 8'hFF);
    cmp("par ignore", 16'h0000, {8'h00, pd & 8'h0F});
    par(1'b0, 8'hB0);
    par(1'b1, 8'hFF);
    cmp("par nibble", 16'h0005, {8'h00, pd & 8'h0F});
    par(1'b0, 8'h6A);
    par(1'b0, 8'h5C);
    cmp("par eoc wr", 16'h0A5C, {4'h0, eoc_message});
    par(1'b0, 8'hE0);
    par(1'b1, 8'hFF);
    cmp("par eoc hi", 16'h000A, {8'h00, pd});
    par(1'b1, 8'hFF);
    cmp("par eoc lo", 16'h005C, {8'h00, pd});
    par(1'b0, 8'h76);
    par(1'b0, 8'h08);
    cmp("par gci", 16'h0001, {15'h0000, tdm_gci_mode});
    pulse();
    cmp("par irq", 16'h0001, {15'h0000, irq_n_oe});
    par(1'b0, 8'h00);
    cmp("par irq clr", 16'h0000, {15'h0000, irq_n_oe});
    $display("test parallel done");
  endtask : test_par

  // ==========
  // Run and watchdog
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    do_reset(1'b0);
    test_ser_nibble();
    test_ser_eoc();
    test_ser_byte();
    test_ser_irq();
    test_par();
    end_of_test();
  end
endmodule : tb_host_register_access_port
